/* pbsp_burst_index.sv */
// Burst address sequencer for the two low address bits
`timescale 1ns/1ps
module pbsp_burst_index (
    input  wire logic       order,
    input  wire logic [1:0] start,
    input  wire logic [1:0] beat,
    output logic [1:0]      index
);
    // Linear counts up modulo four, interleaved is an xor with the beat
    always_comb begin
        if (order == pbsp_pkg::ORDER_INTERLEAVE) begin
            index = start ^ beat;
        end else begin
            index = start + beat;
        end
    end
endmodule

/* pbsp_ctl_model.sv */
// Memory controller model driving the port's synchronous bus
`timescale 1ns/1ps
module pbsp_ctl_model #(
    parameter int SLEEP_RECOVERY_TIME = 2
) (
    input  wire logic  clk,
    output logic       clock_qualifier_n,
    output logic       select_one_n,
    output logic       select_two,
    output logic       select_three_n,
    output logic       advance_or_load,
    output logic       write_strobe_n,
    output logic [3:0] lane_write_select_n,
    output logic [9:0] addr,
    output logic       burst_order_strap,
    output logic       drive_allow_n,
    output logic       sleep_request,
    output logic [31:0] data_in,
    output logic [3:0] parity_in
);
    logic [36:0] wr_now_ff;
    logic [36:0] wr_next_ff;
    initial begin
        {clock_qualifier_n, advance_or_load, sleep_request, select_two} = 4'h0;
        {select_one_n, select_three_n, write_strobe_n, burst_order_strap} = 4'hF;
        lane_write_select_n = 4'hF;
        addr = 10'h000;
        drive_allow_n = 1'h0;
        {parity_in, data_in} = 36'h0;
        wr_now_ff = 37'h0;
        wr_next_ff = 37'h0;
    end
    // Released lines toggle so a stale value can never pass as good data
    always @(posedge clk) begin
        wr_next_ff <= wr_now_ff;
        if (wr_next_ff[36]) begin
            {parity_in, data_in} <= wr_next_ff[35:0];
        end else begin
            {parity_in, data_in} <= ~{parity_in, data_in};
        end
    end
    task automatic beat(input logic sel, input logic adv, input logic wr_n, input logic dv,
                        input logic [3:0] ln, input logic [9:0] a, input logic [35:0] wd);
        @(posedge clk);
        select_one_n        <= ~sel;
        select_two          <= sel;
        select_three_n      <= ~sel;
        advance_or_load     <= adv;
        write_strobe_n      <= wr_n;
        lane_write_select_n <= ln;
        addr                <= a;
        wr_now_ff           <= {dv, wd};
    endtask
    task automatic gap(input int n);
        repeat (n) beat(1'h0, 1'h0, 1'h1, 1'h0, 4'hF, 10'h000, 36'h0);
    endtask
    task automatic recover();
        gap(SLEEP_RECOVERY_TIME);
    endtask
    task automatic lv(input logic stall, input logic al_n, input logic zz, input logic st);
        @(posedge clk);
        clock_qualifier_n <= stall;
        drive_allow_n     <= al_n;
        sleep_request     <= zz;
        burst_order_strap <= st;
    endtask
endmodule

/* pbsp_pkg.sv */
// Constants and types for the pipelined burst static memory port
package pbsp_pkg;
    localparam int ADDR_W_DEF   = 10;
    localparam int LANES_DEF    = 4;
    localparam int LANE_W       = 9;
    localparam logic ORDER_LINEAR     = 1'h0;
    localparam logic ORDER_INTERLEAVE = 1'h1;
    localparam logic [1:0] BEAT_ZERO  = 2'h0;
    localparam logic [1:0] BEAT_ONE   = 2'h1;
    localparam int SLEEP_CYCLES = 2;
    localparam logic [1:0] SLEEP_CNT_LAST = 2'h1;
    typedef enum logic [2:0] {
        PBSP_AWAKE    = 3'h1,
        PBSP_ENTERING = 3'h2,
        PBSP_ASLEEP   = 3'h4
    } pbsp_sleep_t;
endpackage

/* pbsp_port.sv */
// Pipelined burst static memory port: storage, burst, pipelined read and write
// Summary of operation
// - Clock qualifier high freezes burst, write and read state for that edge; input flops, enables and sleep logic still clock.
// - Inputs registered on the rising edge; read data through output registers.
// - All selects active with load at a qualified edge starts an access.
// - Read data appears after the next qualified edge when drive allowed.
// - Output drivers governed by drive allow and internal control after first clock.
// - A new command may follow a read in the very next cycle.
// - Deselect is pipelined; outputs float after the following edge.
// - Burst counter gives up to four accesses from one start address.
// - Strap low selects linear order, high selects interleaved order.
// - Counter acts on the two low address bits and wraps within four.
// - Advance high continues the burst, ignoring selects and write strobe.
// - Direction captured at burst start and kept through the burst.
// - Write load registers address, write control and lane selects.
// - Edge after a write command floats the data drivers.
// - Write data is captured two edges after the command.
// - Only lanes with active lane select are written, with their parity.
// - Sleep request enters a data-preserving sleep; entry and exit take two cycles.
// - Outputs float in the first clock after leaving deselect.
// - After reset the port is deselected with outputs floating.
// - Write with no lane selected writes nothing and outputs float.
`timescale 1ns/1ps
module pbsp_port #(
    parameter int ADDR_W = pbsp_pkg::ADDR_W_DEF,
    parameter int LANES  = pbsp_pkg::LANES_DEF
) (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      clock_qualifier_n,
    input  wire logic                      select_one_n,
    input  wire logic                      select_two,
    input  wire logic                      select_three_n,
    input  wire logic                      advance_or_load,
    input  wire logic                      write_strobe_n,
    input  wire logic [LANES-1:0]          lane_write_select_n,
    input  wire logic [ADDR_W-1:0]         addr,
    input  wire logic                      burst_order_strap,
    input  wire logic                      drive_allow_n,
    input  wire logic                      sleep_request,
    input  wire logic [LANES*8-1:0]        data_in,
    input  wire logic [LANES-1:0]          parity_in,
    output logic      [LANES*8-1:0]        data_out,
    output logic      [LANES-1:0]          parity_out,
    output logic      [LANES*8-1:0]        data_oe,
    output logic      [LANES-1:0]          parity_oe,
    output logic                           asleep
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int DW    = LANES * pbsp_pkg::LANE_W;

    // ==========================================================
    // Input registers and synchronisers
    // ==========================================================
    logic                 cq_n_ff, sel1_n_ff, sel2_ff, sel3_n_ff, adv_ff, we_n_ff;
    logic [LANES-1:0]     lane_n_ff;
    logic [ADDR_W-1:0]    addr_in_ff;
    logic [LANES*8-1:0]   din_ff;
    logic [LANES-1:0]     pin_ff;
    logic                 oe_m_ff, oe_s_ff, zz_m_ff, zz_s_ff, mode_m_ff, mode_s_ff;

    // Sampling every pin into a register keeps pin timing off the core logic
    always_ff @(posedge clk) begin
        cq_n_ff    <= clock_qualifier_n;
        sel1_n_ff  <= select_one_n;
        sel2_ff    <= select_two;
        sel3_n_ff  <= select_three_n;
        adv_ff     <= advance_or_load;
        we_n_ff    <= write_strobe_n;
        lane_n_ff  <= lane_write_select_n;
        addr_in_ff <= addr;
        din_ff     <= data_in;
        pin_ff     <= parity_in;
    end

    // Asynchronous pins pass two flops; first stage read only by second
    always_ff @(posedge clk) begin
        oe_m_ff   <= drive_allow_n;
        oe_s_ff   <= oe_m_ff;
        zz_m_ff   <= sleep_request;
        zz_s_ff   <= zz_m_ff;
        mode_m_ff <= burst_order_strap;
        mode_s_ff <= mode_m_ff;
    end

    // ==========================================================
    // Command decode
    // ==========================================================
    pbsp_pkg::pbsp_sleep_t sleep_ff;
    logic qual;
    logic selected;
    logic load_cmd;
    logic adv_cmd;
    assign qual     = !cq_n_ff && (sleep_ff == pbsp_pkg::PBSP_AWAKE);
    assign selected = !sel1_n_ff && sel2_ff && !sel3_n_ff;
    assign load_cmd = qual && !adv_ff && selected;
    assign adv_cmd  = qual && adv_ff;

    // ==========================================================
    // Burst state
    // ==========================================================
    logic [ADDR_W-1:0] base_ff;
    logic [1:0]        beat_ff;
    logic              active_ff;
    logic              is_read_ff;
    logic              order_ff;
    logic [1:0]        low_idx;
    logic [1:0]        nxt_beat;
    logic [ADDR_W-1:0] cur_addr;

    assign nxt_beat = load_cmd ? pbsp_pkg::BEAT_ZERO : beat_ff + pbsp_pkg::BEAT_ONE;

    pbsp_burst_index u_index (
        .order (order_ff),
        .start (base_ff[1:0]),
        .beat  (beat_ff),
        .index (low_idx)
    );
    assign cur_addr = {base_ff[ADDR_W-1:2], low_idx};

    // Strap taken from its synchroniser at each load command; reset loads interleaved order
    always_ff @(posedge clk) begin
        if (reset) begin
            order_ff <= pbsp_pkg::ORDER_INTERLEAVE;
        end else if (load_cmd) begin
            order_ff <= mode_s_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            base_ff    <= '0;
            beat_ff    <= pbsp_pkg::BEAT_ZERO;
            active_ff  <= 1'h0;
            is_read_ff <= 1'h1;
        end else if (qual) begin
            if (!adv_ff) begin
                active_ff <= selected;
                if (selected) begin
                    base_ff    <= addr_in_ff;
                    beat_ff    <= nxt_beat;
                    is_read_ff <= we_n_ff;
                end
            end else begin
                beat_ff <= nxt_beat;
            end
        end
    end

    // Lane selects registered with each beat of a write
    logic [LANES-1:0] lane_hold_ff;
    logic [LANES-1:0] cyc_lane_n;
    logic             cyc_write;
    logic             cyc_read;
    assign cyc_write  = qual && active_ff && !is_read_ff;
    assign cyc_read   = qual && active_ff && is_read_ff;

    // Lanes belong to the beat's own command rise, one qualified edge back
    always_ff @(posedge clk) begin
        if (reset) begin
            lane_hold_ff <= '1;
        end else if (qual) begin
            lane_hold_ff <= lane_n_ff;
        end
    end
    assign cyc_lane_n = lane_hold_ff;

    // ==========================================================
    // Write pipeline: data two qualified edges after the command
    // ==========================================================
    logic              wp1_ff;
    logic [ADDR_W-1:0] wa1_ff;
    logic [LANES-1:0]  wl1_ff;

    // One stage is enough: the data rise is the next qualified edge
    always_ff @(posedge clk) begin
        if (reset) begin
            wp1_ff <= 1'h0;
            wa1_ff <= '0;
            wl1_ff <= '1;
        end else if (qual) begin
            wp1_ff <= cyc_write;
            wa1_ff <= cur_addr;
            wl1_ff <= cyc_lane_n;
        end
    end

    // ==========================================================
    // Storage
    // ==========================================================
    logic [DW-1:0] mem_ff [DEPTH];

    // Arrays of flops have no reset; contents survive sleep
    always_ff @(posedge clk) begin
        if (qual && wp1_ff) begin
            for (int i = 0; i < LANES; i++) begin
                if (!wl1_ff[i]) begin
                    mem_ff[wa1_ff][i*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] <=
                        {pin_ff[i], din_ff[i*8 +: 8]};
                end
            end
        end
    end

    // ==========================================================
    // Read pipeline and output registers
    // ==========================================================
    logic rd_ff;
    logic [DW-1:0] word;
    assign word = mem_ff[cur_addr];

    always_ff @(posedge clk) begin
        if (reset) begin
            data_out   <= '0;
            parity_out <= '0;
            rd_ff      <= 1'h0;
        end else if (qual) begin
            rd_ff <= cyc_read;
            if (cyc_read) begin
                for (int i = 0; i < LANES; i++) begin
                    data_out[i*8 +: 8] <= word[i*pbsp_pkg::LANE_W +: 8];
                    parity_out[i]      <= word[i*pbsp_pkg::LANE_W + 8];
                end
            end
        end
    end

    // Enables load on the same edge as the data register, so each read beat
    // is driven with its own word; a stalled edge keeps the read in flight
    logic nxt_drive;
    logic rd_live;
    assign rd_live   = qual ? cyc_read : rd_ff;
    assign nxt_drive = rd_live && !oe_s_ff && (sleep_ff == pbsp_pkg::PBSP_AWAKE);
    always_ff @(posedge clk) begin
        if (reset) begin
            data_oe   <= '0;
            parity_oe <= '0;
        end else begin
            // Write and deselect cycles are not reads, so enables drop
            data_oe   <= {(LANES*8){nxt_drive}};
            parity_oe <= {LANES{nxt_drive}};
        end
    end

    // ==========================================================
    // Sleep control
    // ==========================================================
    logic [1:0] sleep_cnt_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            sleep_ff     <= pbsp_pkg::PBSP_AWAKE;
            sleep_cnt_ff <= '0;
            asleep       <= 1'h0;
        end else begin
            case (sleep_ff)
                pbsp_pkg::PBSP_AWAKE: begin
                    sleep_cnt_ff <= '0;
                    asleep       <= 1'h0;
                    if (zz_s_ff) begin
                        sleep_ff <= pbsp_pkg::PBSP_ENTERING;
                    end
                end
                pbsp_pkg::PBSP_ENTERING: begin
                    if (!zz_s_ff) begin
                        sleep_ff <= pbsp_pkg::PBSP_AWAKE;
                    end else if (sleep_cnt_ff == pbsp_pkg::SLEEP_CNT_LAST) begin
                        sleep_ff     <= pbsp_pkg::PBSP_ASLEEP;
                        sleep_cnt_ff <= '0;
                        asleep       <= 1'h1;
                    end else begin
                        sleep_cnt_ff <= sleep_cnt_ff + 2'h1;
                    end
                end
                pbsp_pkg::PBSP_ASLEEP: begin
                    // Exit waits two cycles before accepting accesses
                    if (zz_s_ff) begin
                        sleep_cnt_ff <= '0;
                    end else if (sleep_cnt_ff == pbsp_pkg::SLEEP_CNT_LAST) begin
                        sleep_ff <= pbsp_pkg::PBSP_AWAKE;
                        asleep   <= 1'h0;
                    end else begin
                        sleep_cnt_ff <= sleep_cnt_ff + 2'h1;
                    end
                end
                default: begin
                    sleep_ff <= pbsp_pkg::PBSP_AWAKE;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    stall_hold_a: assert property (@(posedge clk) disable iff (reset)
        !qual |=> $stable(beat_ff) && $stable(base_ff) && $stable(data_out))
        else $error("state changed on stalled edge");
    load_latch_a: assert property (@(posedge clk) disable iff (reset)
        load_cmd |=> base_ff == $past(addr_in_ff) && beat_ff == 2'h0)
        else $error("address not latched on load");
    read_drive_a: assert property (@(posedge clk) disable iff (reset)
        cyc_read && !oe_s_ff |=> data_oe[0] && parity_oe[0])
        else $error("read data not driven");
    out_load_a: assert property (@(posedge clk) disable iff (reset)
        cyc_read |=> data_out[7:0] == $past(word[7:0]))
        else $error("read word not in output register");
    allow_mask_a: assert property (@(posedge clk) disable iff (reset)
        oe_s_ff |=> !data_oe[0] && !parity_oe[0])
        else $error("drivers on while drive allow is off");
    write_float_a: assert property (@(posedge clk) disable iff (reset)
        cyc_write |=> !data_oe[0])
        else $error("drivers on after write");
    desel_pipe_a: assert property (@(posedge clk) disable iff (reset)
        (qual && !adv_ff && !selected) ##1 qual |=> !data_oe[0])
        else $error("deselect did not float outputs");
    burst_adv_a: assert property (@(posedge clk) disable iff (reset)
        adv_cmd |=> beat_ff == $past(beat_ff) + 2'h1)
        else $error("burst counter did not advance");
    dir_keep_a: assert property (@(posedge clk) disable iff (reset)
        adv_cmd |=> $stable(is_read_ff))
        else $error("direction changed mid burst");
    write_stage_a: assert property (@(posedge clk) disable iff (reset)
        (load_cmd && !we_n_ff) ##1 qual |=> wp1_ff && wl1_ff == $past(lane_n_ff, 2))
        else $error("write stage lost its lanes");
    sleep_entry_a: assert property (@(posedge clk) disable iff (reset)
        (sleep_ff == pbsp_pkg::PBSP_AWAKE && zz_s_ff) ##1 zz_s_ff [*2] |=> asleep)
        else $error("sleep not entered in two cycles");
    sleep_float_a: assert property (@(posedge clk) disable iff (reset)
        asleep |-> !data_oe[0] && !parity_oe[0])
        else $error("drivers on in sleep");
    cover_read_c: cover property (@(posedge clk) cyc_read ##1 data_oe[0]);
    cover_write_c: cover property (@(posedge clk) cyc_write ##1 wp1_ff);
    cover_burst_c: cover property (@(posedge clk) load_cmd ##1 adv_cmd [*3]);
    cover_sleep_c: cover property (@(posedge clk) asleep ##1 !asleep);
    cover_stall_c: cover property (@(posedge clk) (wp1_ff && !qual) ##1 qual);
endmodule

/* test_pipelined_burst_sram_port.sv */
// Self-checking testbench for the pipelined burst static memory port
`timescale 1ns/1ps
module test_pipelined_burst_sram_port;
    localparam logic [35:0] D1 = 36'hA11223344;
    localparam logic [35:0] D2 = 36'h555667788;
    localparam logic [35:0] D3 = 36'hC99AABBCC;
    localparam logic [35:0] D4 = 36'h3DDEEF011;
    logic        clk;
    logic        reset;
    wire logic   clock_qualifier_n;
    wire logic   select_one_n;
    wire logic   select_two;
    wire logic   select_three_n;
    wire logic   advance_or_load;
    wire logic   write_strobe_n;
    wire logic [3:0] lane_write_select_n;
    wire logic [9:0] addr;
    wire logic   burst_order_strap;
    wire logic   drive_allow_n;
    wire logic   sleep_request;
    wire logic [31:0] data_in;
    wire logic [3:0] parity_in;
    logic [31:0] data_out;
    logic [3:0]  parity_out;
    logic [31:0] data_oe;
    logic [3:0]  parity_oe;
    logic        asleep;
    int          mismatches;
    int          checks_done;
    logic [35:0] seen_q[$];
    pbsp_port #(.ADDR_W(10), .LANES(4)) pbsp_port_inst (.clk, .reset, .clock_qualifier_n,
        .select_one_n, .select_two, .select_three_n, .advance_or_load, .write_strobe_n,
        .lane_write_select_n, .addr, .burst_order_strap, .drive_allow_n, .sleep_request,
        .data_in, .parity_in, .data_out, .parity_out, .data_oe, .parity_oe, .asleep);
    pbsp_ctl_model pbsp_ctl_model_inst (.clk, .clock_qualifier_n, .select_one_n,
        .select_two, .select_three_n, .advance_or_load, .write_strobe_n,
        .lane_write_select_n, .addr, .burst_order_strap, .drive_allow_n, .sleep_request,
        .data_in, .parity_in);
    always #50 clk = ~clk;
    // Outputs settle after the edge, so the word on the bus is taken mid-cycle
    always @(negedge clk) begin
        if (data_oe[0] === 1'h1) seen_q.push_back({parity_out, data_out});
    end
    // ==========================================
    // Helpers
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                          input logic [3:0] ln);
        logic [35:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (!ln[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
                r[32 + i] = n[32 + i];
            end
        end
        return r;
    endfunction
    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [3:0] ln, input logic [35:0] d);
        pbsp_ctl_model_inst.beat(1'h1, 1'h0, 1'h0, 1'h1, ln, a, d);
    endtask
    task automatic rd(input logic [9:0] a);
        pbsp_ctl_model_inst.beat(1'h1, 1'h0, 1'h1, 1'h0, 4'hF, a, 36'h0);
    endtask
    task automatic gap(input int n);
        pbsp_ctl_model_inst.gap(n);
    endtask
    task automatic expect_reads(input string what, input logic [35:0] exp[$]);
        gap(8);
        check(what, 36'(exp.size()), 36'(seen_q.size()));
        foreach (exp[i]) check(what, exp[i], seen_q.size() > i ? seen_q[i] : 36'hX);
        seen_q.delete();
    endtask
    task automatic wait_sleep(input logic v);
        int n;
        n = 0;
        while (asleep !== v && n < 8) begin
            @(negedge clk);
            n++;
        end
        check("asleep", 36'(v), 36'(asleep));
        if (asleep !== v) stop_test();
    endtask
    // ==========================================
    // Scenarios
    task automatic t_wr_rd();
        wr(10'h010, 4'h0, D1);
        wr(10'h011, 4'h0, D3);
        wr(10'h010, 4'h5, D2);
        gap(2);
        rd(10'h010);
        rd(10'h011);
        wr(10'h012, 4'h0, D4);
        gap(2);
        rd(10'h012);
        expect_reads("write read", {merge(D1, D2, 4'h5), D3, D4});
    endtask
    task automatic t_burst(input logic o, input logic [1:0] s, input logic [9:0] base);
        logic [35:0] exp[$];
        logic [1:0]  idx;
        pbsp_ctl_model_inst.lv(1'h0, 1'h0, 1'h0, o);
        gap(4);
        for (int k = 0; k < 4; k++) begin
            pbsp_ctl_model_inst.beat(k == 0, k != 0, k != 0, 1'h1, 4'h0,
                                     k == 0 ? base | 10'(s) : 10'h3FF, D1 + 36'(k));
        end
        gap(2);
        for (int k = 0; k < 4; k++) begin
            pbsp_ctl_model_inst.beat(k == 0, k != 0, k == 0, 1'h0, 4'h0, base | 10'(s),
                                     36'h0);
            exp.push_back(D1 + 36'(k));
        end
        for (int k = 0; k < 4; k++) begin
            // Two-bit sum so the linear order wraps inside the group
            idx = o ? s ^ 2'(k) : s + 2'(k);
            rd(base | 10'(idx));
        end
        expect_reads("burst", {exp, exp});
    endtask
    task automatic t_ignored();
        wr(10'h011, 4'hF, D1);
        gap(1);
        pbsp_ctl_model_inst.lv(1'h1, 1'h0, 1'h0, 1'h1);
        wr(10'h011, 4'h0, D4);
        gap(3);
        pbsp_ctl_model_inst.lv(1'h0, 1'h0, 1'h0, 1'h1);
        gap(3);
        rd(10'h011);
        expect_reads("ignored write", {D3});
    endtask
    task automatic t_allow();
        pbsp_ctl_model_inst.lv(1'h0, 1'h1, 1'h0, 1'h1);
        gap(3);
        rd(10'h010);
        gap(2);
        pbsp_ctl_model_inst.lv(1'h0, 1'h0, 1'h0, 1'h1);
        gap(4);
        rd(10'h011);
        gap(1);
        expect_reads("drive allow", {D3});
    endtask
    task automatic t_sleep();
        gap(2);
        pbsp_ctl_model_inst.lv(1'h0, 1'h0, 1'h1, 1'h1);
        wait_sleep(1'h1);
        wr(10'h010, 4'h0, D4);
        gap(2);
        pbsp_ctl_model_inst.lv(1'h0, 1'h0, 1'h0, 1'h1);
        wait_sleep(1'h0);
        pbsp_ctl_model_inst.recover();
        rd(10'h010);
        expect_reads("sleep", {merge(D1, D2, 4'h5)});
    endtask
    initial begin
        clk = 1'h0;
        reset = 1'h1;
        mismatches = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        @(negedge clk);
        check("enables", 36'h0, {data_oe, parity_oe});
        check("asleep", 36'h0, 36'(asleep));
        t_wr_rd();
        t_burst(1'h0, 2'h3, 10'h020);
        t_burst(1'h1, 2'h2, 10'h040);
        t_ignored();
        t_allow();
        t_sleep();
        stop_test();
    end
endmodule
